// ==== rtl/rcs_regs.vh ====
// Register map, field layouts, reset values and timing for the run command
// source selector. Assumes a 32-bit APB slave with word-aligned registers.
`ifndef RCS_REGS_VH
`define RCS_REGS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define RCS_OFF_LANG      12'h000
`define RCS_OFF_ACCESS    12'h004
`define RCS_OFF_INIT      12'h008
`define RCS_OFF_PASSWORD  12'h00c
`define RCS_OFF_SPEED_SRC 12'h010
`define RCS_OFF_RUN_SRC   12'h014
`define RCS_OFF_MFI_FUNC  12'h018
`define RCS_OFF_USER_STORE 12'h01c
`define RCS_OFF_VF_PAT    12'h020
`define RCS_OFF_POWER     12'h024
`define RCS_OFF_PANEL     12'h028
`define RCS_OFF_STATUS    12'h02c
`define RCS_OFF_USER_GRP  12'h030

// ****************************************************************
// Codes and reset values
// ****************************************************************
`define RCS_INIT_NONE     16'h0000
`define RCS_INIT_USER     16'd1110
`define RCS_INIT_TWO      16'd2220
`define RCS_INIT_THREE    16'd3330
`define RCS_LANG_MAX      3'h6
`define RCS_LANG_RST      3'h0
`define RCS_ACC_OPER      2'h0
`define RCS_ACC_RST       2'h2
`define RCS_SRC_PANEL     2'h0
`define RCS_SRC_TERM      2'h1
`define RCS_SRC_SERIAL    2'h2
`define RCS_SRC_OPTION    2'h3
`define RCS_SPD_SRC_RST   2'h1
`define RCS_RUN_SRC_RST   2'h1
`define RCS_FN_THREE_WIRE 8'h00
`define RCS_FN_LOCKOUT    8'h1b
`define RCS_FN_RST        8'h0f
`define RCS_MFI_NUM       5
`define RCS_MFI_FWDREV_3W 3'h0
`define RCS_MFI_FWDREV_5  3'h2

// Panel command register fields
`define RCS_PNL_RUN       0
`define RCS_PNL_REV       1
`define RCS_PNL_EDIT      2
`define RCS_PNL_SER_WR    3
`define RCS_PNL_SER_ENTER 4
`define RCS_PNL_SPEED_OK  5

// ****************************************************************
// Timing
// ****************************************************************
`define RCS_CLK_MHZ       125
`define RCS_RUN_MIN_MS    50
`define RCS_RUN_MIN_CYC   (`RCS_RUN_MIN_MS * `RCS_CLK_MHZ * 1000)
`define RCS_BLINK_CYC     24'd12500000

`endif

// ==== rtl/rcs_param_mem.v ====
// Small parameter store holding the user-default snapshot of parameters.
// Assumes one writer and one reader, both on pclk.
`timescale 1ns/10ps
`default_nettype none

module rcs_param_mem (
  input  wire        pclk,
  input  wire        we,
  input  wire [3:0]  waddr,
  input  wire [31:0] wdata,
  input  wire [3:0]  raddr,
  output reg  [31:0] rdata
);
  reg [31:0] mem [0:15];

  // Read data registered, so a restore takes one cycle per word
  always @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // rcs_param_mem

`default_nettype wire

// ==== rtl/rcs_contact_sync.v ====
// Two-flop synchroniser for the terminal contact inputs.
// Assumes contacts are closed-low to common and arrive asynchronously.
`timescale 1ns/10ps
`default_nettype none

module rcs_contact_sync (
  input  wire       pclk,
  input  wire       presetn,
  input  wire [4:0] contact_n,
  output reg  [4:0] closed
);
  reg [4:0] meta;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta   <= 5'h1f;
      closed <= 5'h00;
    end else begin
      meta   <= contact_n;
      closed <= ~meta;
    end
  end
endmodule // rcs_contact_sync

`default_nettype wire

// ==== rtl/rcs_top.v ====
// Run and speed command source selection, terminal interpretation,
// parameter edit protection and initialisation sequencing.
// Assumes an APB master on pclk and contact inputs closed-low to common.
// Notes on behaviour
// - Init codes 1110, 2220, 3330; zero idles
// - User init restores stored user settings
// - 2-wire init: input one fwd, two rev
// - 3-wire init: one run, two stop, five dir
// - Direction conflict resolved: lowest-numbered function-zero input used
// - Init selector returns to zero afterwards
// - Language untouched by any initialisation
// - 2/3-wire init keeps pattern and power
// - Language codes 0..6, default zero
// - Level 0: only access and password editable
// - Level 2 default: all editable unless protected
// - Password blocks language, access, init, user group
// - Active lockout input blocks parameter changes
// - Serial write pending blocks panel edits, busy
// - Speed source: panel, analog, serial, option
// - Run without speed: run lit, stop blinks
// - Option speed source without board: error, no run
// - Run source selects accepted run command
// - 2-wire: input one fwd, two rev
// - Both closed: stop, flashing external fault
// - Function zero selects 3-wire, input gives direction
// - Run pulse over 50 ms, stop opens stops
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "rcs_regs.vh"

module rcs_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        terminal_input_one,
  input  wire        terminal_input_two,
  input  wire        terminal_input_three,
  input  wire        terminal_input_four,
  input  wire        terminal_input_five,
  input  wire        option_board_present,
  input  wire        serial_run,
  input  wire        serial_rev,
  input  wire        serial_speed_valid,
  input  wire        option_run,
  input  wire        option_rev,
  input  wire        option_speed_valid,
  input  wire        analog_speed_valid,
  output reg         run_enable,
  output reg         run_reverse,
  output reg         run_lamp,
  output reg         stop_lamp,
  output reg         external_fault_alarm,
  output reg         option_missing_error,
  output reg         edit_busy,
  output reg         init_busy
);

  // ****************************************************************
  // Parameters and state
  // ****************************************************************
  reg [2:0]  display_language_select;
  reg [1:0]  access_level_select;
  reg [15:0] initialize_select;
  reg [15:0] password_param;
  reg [1:0]  speed_ref_source_select;
  reg [1:0]  run_source_select;
  reg [39:0] multifunction_input_function;
  reg [7:0]  vf_pattern_select;
  reg [7:0]  rated_power_select;
  reg [31:0] user_parameter_group;
  reg [5:0]  panel_cmd;
  reg        serial_pending;
  reg        password_lock;
  reg [1:0]  init_state;
  reg [3:0]  init_step;
  reg        three_run;
  reg [22:0] run_width;
  reg [23:0] blink_cnt;
  reg        blink;
  reg        wire3_by_init;

  localparam ST_IDLE  = 2'b00;
  localparam ST_USER  = 2'b01;
  localparam ST_LOAD  = 2'b10;
  localparam ST_DONE  = 2'b11;

  wire [4:0] closed;
  wire [31:0] mem_rdata;

  rcs_contact_sync u_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .contact_n ({terminal_input_five, terminal_input_four, terminal_input_three,
                 terminal_input_two, terminal_input_one}),
    .closed    (closed)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function fn_any;
    input [39:0] fns;
    input [7:0]  code;
    input [4:0]  act;
    input        need_act;
    integer i;
    begin
      fn_any = 1'b0;
      for (i = 0; i < `RCS_MFI_NUM; i = i + 1) begin
        if (fns[i*8 +: 8] == code && (!need_act || act[i])) begin
          fn_any = 1'b1;
        end
      end
    end
  endfunction

  // Multi-function inputs are terminals three to five plus one and two
  wire [4:0] mfi_act = {closed[4], closed[3], closed[2], closed[1], closed[0]};
  wire three_wire = fn_any(multifunction_input_function, `RCS_FN_THREE_WIRE,
                           5'h00, 1'b0);
  wire lockout = fn_any(multifunction_input_function, `RCS_FN_LOCKOUT,
                        mfi_act, 1'b1);
  // Direction input: index of the function-zero input, else terminal five
  reg  dir_closed;
  integer k;
  always @* begin
    dir_closed = closed[4];
    for (k = `RCS_MFI_NUM - 1; k >= 0; k = k - 1) begin
      if (multifunction_input_function[k*8 +: 8] == `RCS_FN_THREE_WIRE) begin
        dir_closed = closed[k];
      end
    end
  end

  // ****************************************************************
  // APB access and edit protection
  // ****************************************************************
  wire access   = psel && penable && !pready;
  wire wr       = access && pwrite;
  wire [11:0] a = paddr;
  wire is_param = (a <= `RCS_OFF_POWER) || (a == `RCS_OFF_USER_GRP);
  wire pw_area  = (a == `RCS_OFF_LANG) || (a == `RCS_OFF_ACCESS) ||
                  (a == `RCS_OFF_INIT) || (a == `RCS_OFF_USER_GRP);
  wire lvl0_ok  = (a == `RCS_OFF_ACCESS) || (a == `RCS_OFF_PASSWORD);
  // Password holds while a non-zero password is set and not unlocked
  wire blocked  = is_param && (
                  (access_level_select == `RCS_ACC_OPER && !lvl0_ok) ||
                  (password_lock && pw_area) ||
                  lockout ||
                  serial_pending ||
                  (init_state != ST_IDLE));
  wire wr_ok    = wr && !blocked;
  wire mapped   = (a <= `RCS_OFF_USER_GRP) && (a[1:0] == 2'b00);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access;
      pslverr <= access && (!mapped || (pwrite && blocked));
      if (access && !pwrite) begin
        case (a)
          `RCS_OFF_LANG:       prdata <= {29'h0, display_language_select};
          `RCS_OFF_ACCESS:     prdata <= {30'h0, access_level_select};
          `RCS_OFF_INIT:       prdata <= {16'h0, initialize_select};
          `RCS_OFF_PASSWORD:   prdata <= {31'h0, password_lock};
          `RCS_OFF_SPEED_SRC:  prdata <= {30'h0, speed_ref_source_select};
          `RCS_OFF_RUN_SRC:    prdata <= {30'h0, run_source_select};
          `RCS_OFF_MFI_FUNC:   prdata <= multifunction_input_function[31:0];
          `RCS_OFF_VF_PAT:     prdata <= {24'h0, vf_pattern_select};
          `RCS_OFF_POWER:      prdata <= {24'h0, rated_power_select};
          `RCS_OFF_PANEL:      prdata <= {26'h0, panel_cmd};
          `RCS_OFF_STATUS:     prdata <= {22'h0, init_busy, edit_busy,
                                          option_missing_error, external_fault_alarm,
                                          stop_lamp, run_lamp, run_reverse,
                                          run_enable, closed[1:0]};
          `RCS_OFF_USER_GRP:   prdata <= user_parameter_group;
          default:             prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Initialisation sequencer with user snapshot memory
  // ****************************************************************
  wire store_user = wr_ok && (a == `RCS_OFF_USER_STORE) && (pwdata[0] == 1'b1);
  reg  [3:0]  mem_waddr;
  reg  [31:0] mem_wdata;
  reg         snap_busy;
  reg  [3:0]  snap_idx;

  always @* begin
    case (snap_idx)
      4'h0:    mem_wdata = {30'h0, access_level_select};
      4'h1:    mem_wdata = {30'h0, speed_ref_source_select};
      4'h2:    mem_wdata = {30'h0, run_source_select};
      4'h3:    mem_wdata = multifunction_input_function[31:0];
      4'h4:    mem_wdata = {24'h0, multifunction_input_function[39:32]};
      4'h5:    mem_wdata = {24'h0, vf_pattern_select};
      4'h6:    mem_wdata = {24'h0, rated_power_select};
      4'h7:    mem_wdata = user_parameter_group;
      default: mem_wdata = 32'h0000_0000;
    endcase
    mem_waddr = snap_idx;
  end

  rcs_param_mem u_mem (
    .pclk  (pclk),
    .we    (snap_busy),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (init_step),
    .rdata (mem_rdata)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      display_language_select      <= `RCS_LANG_RST;
      access_level_select          <= `RCS_ACC_RST;
      initialize_select            <= `RCS_INIT_NONE;
      password_param               <= 16'h0000;
      password_lock                <= 1'b0;
      speed_ref_source_select      <= `RCS_SPD_SRC_RST;
      run_source_select            <= `RCS_RUN_SRC_RST;
      multifunction_input_function <= {5{`RCS_FN_RST}};
      vf_pattern_select            <= 8'h00;
      rated_power_select           <= 8'h00;
      user_parameter_group         <= 32'h0000_0000;
      panel_cmd                    <= 6'h00;
      serial_pending               <= 1'b0;
      init_state                   <= ST_IDLE;
      init_step                    <= 4'h0;
      snap_busy                    <= 1'b0;
      snap_idx                     <= 4'h0;
      wire3_by_init                <= 1'b0;
    end else begin
      // Serial write holds the panel off until the host sends Enter
      if (serial_pending && panel_cmd[`RCS_PNL_SER_ENTER]) begin
        serial_pending <= 1'b0;
      end
      if (panel_cmd[`RCS_PNL_SER_WR]) begin
        serial_pending <= 1'b1;
      end
      if (wr && a == `RCS_OFF_PANEL) begin
        panel_cmd <= pwdata[5:0];
      end else begin
        panel_cmd[`RCS_PNL_SER_WR]    <= 1'b0;
        panel_cmd[`RCS_PNL_SER_ENTER] <= 1'b0;
      end
      if (snap_busy) begin
        snap_idx  <= snap_idx + 4'h1;
        snap_busy <= (snap_idx != 4'h7);
      end else if (store_user) begin
        snap_busy <= 1'b1;
        snap_idx  <= 4'h0;
      end
      if (wr_ok) begin
        case (a)
          `RCS_OFF_LANG:
            if (pwdata[2:0] <= `RCS_LANG_MAX) display_language_select <= pwdata[2:0];
          `RCS_OFF_ACCESS:    access_level_select <= pwdata[1:0];
          `RCS_OFF_INIT:
            if (pwdata[15:0] == `RCS_INIT_USER || pwdata[15:0] == `RCS_INIT_TWO ||
                pwdata[15:0] == `RCS_INIT_THREE) initialize_select <= pwdata[15:0];
          `RCS_OFF_PASSWORD: begin
            if (password_param == 16'h0000 || pwdata[15:0] == password_param) begin
              password_lock <= 1'b0;
            end
            if (pwdata[31]) begin
              password_param <= pwdata[15:0];
              password_lock  <= (pwdata[15:0] != 16'h0000);
            end
          end
          `RCS_OFF_SPEED_SRC: speed_ref_source_select <= pwdata[1:0];
          `RCS_OFF_RUN_SRC:   run_source_select <= pwdata[1:0];
          `RCS_OFF_MFI_FUNC:  multifunction_input_function[31:0] <= pwdata;
          `RCS_OFF_VF_PAT:    vf_pattern_select <= pwdata[7:0];
          `RCS_OFF_POWER:     rated_power_select <= pwdata[7:0];
          `RCS_OFF_USER_GRP:  user_parameter_group <= pwdata;
          default: ;
        endcase
      end
      case (init_state)
        ST_IDLE: begin
          init_step <= 4'h0;
          if (initialize_select == `RCS_INIT_USER) begin
            init_state <= ST_USER;
          end else if (initialize_select != `RCS_INIT_NONE) begin
            init_state <= ST_LOAD;
          end
        end
        ST_USER: begin
          // Registered memory: word for step n-1 arrives at step n
          init_step <= init_step + 4'h1;
          case (init_step)
            4'h1: access_level_select          <= mem_rdata[1:0];
            4'h2: speed_ref_source_select      <= mem_rdata[1:0];
            4'h3: run_source_select            <= mem_rdata[1:0];
            4'h4: multifunction_input_function[31:0]  <= mem_rdata;
            4'h5: multifunction_input_function[39:32] <= mem_rdata[7:0];
            4'h6: vf_pattern_select            <= mem_rdata[7:0];
            4'h7: rated_power_select           <= mem_rdata[7:0];
            4'h8: user_parameter_group         <= mem_rdata;
            default: ;
          endcase
          if (init_step == 4'h8) begin
            init_state <= ST_DONE;
          end
        end
        ST_LOAD: begin
          // Language, pattern and power kept on purpose
          access_level_select     <= `RCS_ACC_RST;
          speed_ref_source_select <= `RCS_SPD_SRC_RST;
          run_source_select       <= `RCS_RUN_SRC_RST;
          user_parameter_group    <= 32'h0000_0000;
          if (initialize_select == `RCS_INIT_THREE) begin
            // Input five carries direction; one to four kept default
            multifunction_input_function <= {`RCS_FN_THREE_WIRE, {4{`RCS_FN_RST}}};
            wire3_by_init <= 1'b1;
          end else begin
            multifunction_input_function <= {5{`RCS_FN_RST}};
            wire3_by_init <= 1'b0;
          end
          init_state <= ST_DONE;
        end
        ST_DONE: begin
          initialize_select <= `RCS_INIT_NONE;
          init_state        <= ST_IDLE;
        end
        default: init_state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Terminal interpretation and run qualification
  // ****************************************************************
  wire both_closed = !three_wire && closed[0] && closed[1];
  wire run_long    = (run_width >= (`RCS_RUN_MIN_CYC - 1));

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_width <= 23'h000000;
      three_run <= 1'b0;
      blink_cnt <= 24'h000000;
      blink     <= 1'b0;
    end else begin
      if (closed[0] && closed[1]) begin
        if (!run_long) run_width <= run_width + 23'h000001;
      end else begin
        run_width <= 23'h000000;
      end
      if (!three_wire || !closed[1]) begin
        three_run <= 1'b0;
      end else if (run_long) begin
        three_run <= 1'b1;
      end
      if (blink_cnt == `RCS_BLINK_CYC) begin
        blink_cnt <= 24'h000000;
        blink     <= !blink;
      end else begin
        blink_cnt <= blink_cnt + 24'h000001;
      end
    end
  end

  // ****************************************************************
  // Source selection and indicators
  // ****************************************************************
  reg next_run;
  reg next_rev;
  reg next_speed;
  always @* begin
    case (run_source_select)
      `RCS_SRC_PANEL:  begin next_run = panel_cmd[`RCS_PNL_RUN]; next_rev = panel_cmd[`RCS_PNL_REV]; end
      `RCS_SRC_TERM:   begin
        if (three_wire) begin
          next_run = three_run;
          next_rev = dir_closed;
        end else begin
          next_run = closed[0] ^ closed[1];
          next_rev = closed[1] && !closed[0];
        end
      end
      `RCS_SRC_SERIAL: begin next_run = serial_run; next_rev = serial_rev; end
      default:         begin next_run = option_run; next_rev = option_rev; end
    endcase
    case (speed_ref_source_select)
      `RCS_SRC_PANEL:  next_speed = panel_cmd[`RCS_PNL_SPEED_OK];
      `RCS_SRC_TERM:   next_speed = analog_speed_valid;
      `RCS_SRC_SERIAL: next_speed = serial_speed_valid;
      default:         next_speed = option_speed_valid && option_board_present;
    endcase
  end

  wire opt_missing = (speed_ref_source_select == `RCS_SRC_OPTION) && !option_board_present;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_enable           <= 1'b0;
      run_reverse          <= 1'b0;
      run_lamp             <= 1'b0;
      stop_lamp            <= 1'b1;
      external_fault_alarm <= 1'b0;
      option_missing_error <= 1'b0;
      edit_busy            <= 1'b0;
      init_busy            <= 1'b0;
    end else begin
      option_missing_error <= opt_missing;
      external_fault_alarm <= (run_source_select == `RCS_SRC_TERM) && both_closed && !blink;
      run_enable  <= next_run && next_speed && !opt_missing && !both_closed;
      run_reverse <= next_rev;
      run_lamp    <= next_run;
      stop_lamp   <= !next_run || (!next_speed && blink);
      edit_busy   <= serial_pending && panel_cmd[`RCS_PNL_EDIT];
      init_busy   <= (init_state != ST_IDLE) || snap_busy;
    end
  end
endmodule // rcs_top

`default_nettype wire

// ==== tb/rcs_top_assertions.sv ====
// Checker for rcs_top: APB answer timing and run inhibit.
// Sees only top-level ports; attached by the bind at the foot.
`timescale 1ns/10ps
`default_nettype none
module rcs_top_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic run_enable,
  input wire logic stop_lamp,
  input wire logic external_fault_alarm,
  input wire logic option_missing_error,
  input wire logic option_board_present
);
  // ********
  // Properties
  // ********
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_taken;
    psel && penable && !pready;
  endsequence
  sequence s_board_held;
    option_board_present [*3];
  endsequence
  a_one_wait: assert property (s_taken |=> pready)
    else $error("late answer");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("lone error");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("stray ready");
  a_fault_stop: assert property (external_fault_alarm |-> ##[0:2] !run_enable)
    else $error("run during fault");
  a_option_stop: assert property (option_missing_error |-> ##[0:2] !run_enable)
    else $error("run without board");
  a_option_clear: assert property (s_board_held |-> !option_missing_error)
    else $error("error with board");
  a_reset_idle: assert property (disable iff (1'b0) !presetn |-> stop_lamp && !run_enable)
    else $error("reset outputs");
endmodule // rcs_top_chk
bind rcs_top rcs_top_chk chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .run_enable, .stop_lamp, .external_fault_alarm, .option_missing_error,
  .option_board_present);
`default_nettype wire

// ==== tb/rcs_field_model.sv ====
// Field side: contacts closed low to common, serial and option host lines.
// Contacts move off the clock, as real switches do.
`timescale 1ns/10ps
`default_nettype none
module rcs_field_model (
  input  wire logic [4:0] closed,
  input  wire logic [6:0] host_in,
  output var  logic [4:0] contact_n,
  output wire logic [6:0] host_out
);
  initial contact_n = 5'h1f;
  always @(closed) contact_n <= #3 ~closed;
  assign host_out = host_in;
endmodule // rcs_field_model
`default_nettype wire

// ==== tb/rcs_top_tb_top.sv ====
// Self-checking bench for rcs_top over APB and the contact inputs.
// Assumes the design, checker and field model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module rcs_top_tb_top;
  logic        pclk = 0;
  logic        presetn = 1;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [4:0]  closed = 0;
  logic [6:0]  host = 0;
  logic        option_board_present = 0;
  logic [2:0]  lang;
  logic [64:0] note;
  logic [64:0] notes[$];
  int          fail_count = 0;
  int          comparisons = 0;
  wire  [31:0] prdata;
  wire  [4:0]  cn;
  wire  [6:0]  hs;
  wire         pready, pslverr, run_enable, run_reverse, run_lamp, stop_lamp;
  wire         external_fault_alarm, option_missing_error, edit_busy, init_busy;
  rcs_field_model fm (.closed(closed), .host_in(host), .contact_n(cn), .host_out(hs));
  rcs_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .terminal_input_one(cn[0]), .terminal_input_two(cn[1]),
    .terminal_input_three(cn[2]), .terminal_input_four(cn[3]),
    .terminal_input_five(cn[4]), .option_board_present, .serial_run(hs[0]),
    .serial_rev(hs[1]), .serial_speed_valid(hs[2]), .option_run(hs[3]),
    .option_rev(hs[4]), .option_speed_valid(hs[5]), .analog_speed_valid(hs[6]),
    .run_enable, .run_reverse, .run_lamp, .stop_lamp, .external_fault_alarm,
    .option_missing_error, .edit_busy, .init_busy);
  // ********
  // Tasks
  // ********
  initial forever #4 pclk = ~pclk;
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, m, e,
                      input logic err);
    notes.push_back({err, m, e});
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err);
    xfer(1, a, d, 0, 0, err);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, e);
    xfer(0, a, 0, m, e, 0);
  endtask
  task automatic settle;
    repeat (8) @(posedge pclk);
  endtask
  task automatic wait_init;
    repeat (3) @(posedge pclk);
    while (init_busy !== 1'b0) @(posedge pclk);
  endtask
  task automatic chk(input string s, input logic e, g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %b got %b", s, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Results are matched to the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      note = notes.pop_front();
      comparisons++;
      if ({pslverr, prdata & note[63:32]} !== {note[64], note[31:0]}) begin
        fail_count++;
        $display("MISMATCH apb %h exp %h got %h", paddr, note, {pslverr, prdata});
      end
    end
  end
  initial begin
    repeat (30000) @(posedge pclk);
    fail_count++;
    print_verdict;
  end
  initial begin
    presetn <= 0;
    void'($urandom(73));
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rd(12'h000, 7, 0);
    rd(12'h004, 3, 2);
    rd(12'h008, 32'hffff, 0);
    rd(12'h014, 3, 1);
    xfer(0, 12'h034, 0, 0, 0, 1);
    repeat (3) begin
      lang = 3'($urandom % 7);
      wr(12'h000, {29'h0, lang}, 0);
      rd(12'h000, 7, {29'h0, lang});
    end
    wr(12'h000, 7, 0);
    rd(12'h000, 7, {29'h0, lang});
    wr(12'h020, 1, 0);
    wr(12'h01c, 1, 0);
    wait_init;
    wr(12'h010, 2, 0);
    wr(12'h008, 32'd1110, 0);
    wait_init;
    rd(12'h010, 3, 1);
    wr(12'h008, 32'd2220, 0);
    wait_init;
    rd(12'h008, 32'hffff, 0);
    rd(12'h000, 7, {29'h0, lang});
    rd(12'h020, 32'hf, 1);
    host <= 7'h40;
    closed <= 5'h01;
    settle;
    rd(12'h02c, 32'hc, 32'h4);
    closed <= 5'h02;
    settle;
    rd(12'h02c, 32'hc, 32'hc);
    closed <= 5'h03;
    settle;
    rd(12'h02c, 32'h44, 32'h40);
    host <= 0;
    closed <= 5'h01;
    settle;
    chk("run_lamp", 1, run_lamp);
    closed <= 0;
    host <= 7'h28;
    wr(12'h010, 3, 0);
    wr(12'h014, 3, 0);
    settle;
    chk("option_missing_error", 1, option_missing_error);
    chk("run_enable", 0, run_enable);
    option_board_present <= 1;
    settle;
    chk("run_enable", 1, run_enable);
    for (int s = 0; s < 4; s++) begin
      wr(12'h010, s, 0);
      rd(12'h010, 3, s);
    end
    wr(12'h028, 32'hc, 0);
    settle;
    chk("edit_busy", 1, edit_busy);
    wr(12'h000, 1, 1);
    wr(12'h028, 32'h10, 0);
    wr(12'h000, 1, 0);
    wr(12'h004, 0, 0);
    wr(12'h000, 2, 1);
    wr(12'h004, 2, 0);
    wr(12'h018, 32'h1b1b1b1b, 0);
    closed <= 5'h08;
    settle;
    wr(12'h000, 3, 1);
    closed <= 0;
    settle;
    wr(12'h000, 3, 0);
    wr(12'h008, 32'd3330, 0);
    wait_init;
    closed <= 5'h07;
    settle;
    rd(12'h02c, 32'h8, 0);
    closed <= 5'h13;
    settle;
    rd(12'h02c, 32'h8, 32'h8);
    rd(12'h02c, 32'h4, 0);
    print_verdict;
  end
endmodule // rcs_top_tb_top
`default_nettype wire
